// [hdl/ccsu_pkg.sv]
// Purpose: Shared constants for the common command and status unit.
// Assumes: One 40 MHz clock; the command parser and subsystems share it.
// Notes: Tags mark the logic.
// Function
// - Option report lists keyword or zero, fixed order
// - Option report is query only, never written
// - Clear-at-power-on set: masks cleared at power-up
// - Clear-at-power-on off: masks reloaded from nonvolatile
// - Recall restores whole saved state from slot
// - Recall forces calibration off, aborts trigger
// - Save writes present state into one of eight slots
// - Reset loads the factory default settings
// - Reset command equals bus device clear
// - Reset clears status, keeps enable masks
// - Masked status byte ORed into bit six
// - Zero request mask never raises service request
// - Serial poll clears request flag, keeps summary
// - Serial poll returns request flag in bit six
// - Status byte query leaves byte unchanged
// - Summary bits clear only by reading sources
// - Status byte bit layout, bits two-zero unused
// - Bus trigger fires bus-sourced subsystems like GET
// - Output, relay, trigger commands run overlapped
// - Wait holds off until overlapped work completes
// - Any later command except wait abandons the wait
// - Masked event register sets event summary bit
// - Reading event register returns then clears it
package ccsu_pkg;

    // ----------------------------------------------------------------
    // Command codes from the parser
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_CLS = 4'h0, CMD_ESE = 4'h1, CMD_ESEQ = 4'h2, CMD_ESRQ = 4'h3,
        CMD_OPTQ = 4'h4, CMD_PSC = 4'h5, CMD_PSCQ = 4'h6, CMD_RCL = 4'h7,
        CMD_RST = 4'h8, CMD_SAV = 4'h9, CMD_SRE = 4'ha, CMD_SREQ = 4'hb,
        CMD_STBQ = 4'hc, CMD_TRG = 4'hd, CMD_WAI = 4'he, CMD_OTHER = 4'hf
    } ccsu_cmd_t;

    // ----------------------------------------------------------------
    // Status byte and event register bit positions
    // ----------------------------------------------------------------
    localparam int STB_OPR = 7;
    localparam int STB_SUM = 6;
    localparam int STB_EVT = 5;
    localparam int STB_MSG = 4;
    localparam int STB_QST = 3;
    localparam int ESR_PWR = 7;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Saved instrument state layout
    // ----------------------------------------------------------------
    localparam int SLOTS = 8;
    localparam int SLOT_W = 3;
    localparam int CFG_W = 56;
    localparam int F_CONT = 0;
    localparam int F_OUT = 1;
    localparam int F_TSRC = 2;
    localparam int F_VSLEW = 4;
    localparam int F_FSLEW = 5;
    localparam int F_PHASE = 6;
    localparam int F_DELAY = 16;
    localparam int F_FREQ = 32;
    localparam int F_LIST = 48;
    localparam logic [1:0] TSRC_IMM = 2'h0;
    localparam logic [1:0] TSRC_BUS = 2'h1;
    localparam logic [9:0] PHASE_DEF = 10'h000;
    localparam logic [15:0] DELAY_DEF_MS = 16'h0064;
    localparam logic [15:0] FREQ_DEF_HZ = 16'h003c;
    localparam logic [7:0] LIST_DEF = 8'h00;
    localparam logic [CFG_W-1:0] CFG_DEFAULT = {LIST_DEF, FREQ_DEF_HZ, DELAY_DEF_MS,
        PHASE_DEF, 1'b1, 1'b1, TSRC_IMM, 1'b0, 1'b0};

    // ----------------------------------------------------------------
    // Option report: fixed order, field n keyword id is n+1
    // ----------------------------------------------------------------
    localparam int OPT_N = 14;
    localparam logic [3:0] OPT_LAST = 4'hd;
    localparam logic [13:0] OPT_INSTALLED = 14'h0001;

endpackage

// [hdl/ccsu_status_byte.sv]
// Purpose: Builds the status byte and the master summary from its sources.
// Assumes: All inputs are on clk_sys; purely combinational.
// Notes: Summaries clear only when their source registers are cleared.
`timescale 1ns/10ps
module ccsu_status_byte
    import ccsu_pkg::*;
(
    // Sources
    input wire logic operSummary,
    input wire logic questSummary,
    input wire logic msgAvail,
    input wire logic [7:0] eventReg,
    input wire logic [7:0] eventMask,
    // Mask and result
    input wire logic [7:0] requestMask,
    output logic masterSummary,
    output logic [7:0] statusByte
);
    logic [7:0] bare;

    // Bit six is excluded from the masking so the summary cannot feed itself.
    always_comb begin
        bare = 8'h00;
        bare[STB_OPR] = operSummary;
        bare[STB_EVT] = |(eventReg & eventMask);
        bare[STB_MSG] = msgAvail;
        bare[STB_QST] = questSummary;
        masterSummary = |(bare & requestMask);
        statusByte = bare;
        statusByte[STB_SUM] = masterSummary;
    end
endmodule

// [hdl/ccsu_slot_store.sv]
// Purpose: Eight slots of saved instrument state held in flip-flops.
// Assumes: One write per cycle; read is combinational by index.
// Notes: Slots start at factory defaults after reset.
`timescale 1ns/10ps
module ccsu_slot_store
    import ccsu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Write side
    input wire logic wrEn,
    input wire logic [SLOT_W-1:0] wrIdx,
    input wire logic [CFG_W-1:0] wrData,
    // Read side
    input wire logic [SLOT_W-1:0] rdIdx,
    output logic [CFG_W-1:0] rdData
);
    typedef struct packed {
        logic [SLOTS-1:0][CFG_W-1:0] slot;
    } ccsu_store_t;

    ccsu_store_t st_reg;
    ccsu_store_t st_next;

    // Write one slot, transient list field included.
    always_comb begin
        st_next = st_reg;
        if (wrEn) begin
            st_next.slot[wrIdx] = wrData;
        end
    end

    // Slots reset to the factory state.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= {SLOTS{CFG_DEFAULT}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdData = st_reg.slot[rdIdx];
endmodule

// [hdl/ccsu_core.sv]
// Purpose: Executes common commands and keeps status byte and request logic.
// Assumes: Parser, subsystems and power sequencer all run on clk_sys.
// Notes: Nonvolatile storage lives outside; this block loads and writes it.
`timescale 1ns/10ps
module ccsu_core
    import ccsu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Command port from the parser
    input wire logic cmdValid,
    input wire logic [3:0] cmdCode,
    input wire logic [7:0] cmdArg,
    output logic cmdReady,
    // Query answers
    output logic respValid,
    output logic [7:0] respData,
    output logic respLast,
    // Instrument bus events
    input wire logic devClear,
    input wire logic groupTrig,
    input wire logic pollReq,
    output logic pollValid,
    output logic [7:0] pollData,
    output logic srq,
    // Status sources
    input wire logic operSummary,
    input wire logic questSummary,
    input wire logic msgAvail,
    input wire logic [7:0] eventSet,
    output logic statusClear,
    // Power-up and nonvolatile mask storage
    input wire logic powerUp,
    input wire logic nvClearFlag,
    input wire logic [7:0] nvRequestMask,
    input wire logic [7:0] nvEventMask,
    output logic nvWrite,
    output logic nvClearFlagOut,
    output logic [7:0] nvRequestMaskOut,
    output logic [7:0] nvEventMaskOut,
    // Instrument settings
    input wire logic cfgLoad,
    input wire logic [CFG_W-1:0] cfgIn,
    output logic [CFG_W-1:0] cfgOut,
    output logic calEnable,
    input wire logic calOn,
    // Trigger and overlap
    output logic busTrigger,
    output logic transientTrig,
    output logic trigAbort,
    input wire logic overlapBusy,
    output logic waitHold
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] reqMask;
        logic [7:0] evtMask;
        logic [7:0] evtReg;
        logic clrFlag;
        logic rfs;
        logic sumPrev;
        logic waitPend;
        logic [CFG_W-1:0] cfg;
        logic cal;
        logic rValid;
        logic [7:0] rData;
        logic rLast;
        logic optBusy;
        logic [3:0] optIdx;
        logic trig;
        logic ownTrig;
        logic abort;
        logic clr;
        logic nvWr;
        logic pValid;
        logic [7:0] pData;
    } ccsu_core_t;

    localparam ccsu_core_t CORE_RESET = '{
        reqMask: MASK_RESET, evtMask: MASK_RESET, evtReg: 8'h00, clrFlag: 1'b1,
        rfs: 1'b0, sumPrev: 1'b0, waitPend: 1'b0, cfg: CFG_DEFAULT, cal: 1'b0,
        rValid: 1'b0, rData: 8'h00, rLast: 1'b0, optBusy: 1'b0, optIdx: 4'h0,
        trig: 1'b0, ownTrig: 1'b0, abort: 1'b0, clr: 1'b0, nvWr: 1'b0,
        pValid: 1'b0, pData: 8'h00};

    ccsu_core_t s_reg;
    ccsu_core_t s_next;

    logic take;
    ccsu_cmd_t cmd;
    logic sum;
    logic [7:0] stb;
    logic [CFG_W-1:0] slotData;
    logic doReset;
    logic doTrig;

    // Field id for one position of the option report, zero when absent.
    function automatic logic [7:0] optField(input logic [3:0] idx);
        optField = OPT_INSTALLED[idx] ? {4'h0, idx} + 8'h01 : 8'h00;
    endfunction

    // The option report blocks new commands while it streams out.
    assign take = cmdValid && cmdReady;
    assign cmdReady = !s_reg.optBusy;
    assign cmd = ccsu_cmd_t'(cmdCode);
    assign doReset = (take && cmd == CMD_RST) || devClear;
    assign doTrig = (take && cmd == CMD_TRG) || groupTrig;

    // ----------------------------------------------------------------
    // Status byte and saved slots
    // ----------------------------------------------------------------
    ccsu_status_byte u_stb (
        .operSummary(operSummary),
        .questSummary(questSummary),
        .msgAvail(msgAvail),
        .eventReg(s_reg.evtReg),
        .eventMask(s_reg.evtMask),
        .requestMask(s_reg.reqMask),
        .masterSummary(sum),
        .statusByte(stb)
    );

    ccsu_slot_store u_store (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wrEn(take && cmd == CMD_SAV),
        .wrIdx(cmdArg[SLOT_W-1:0]),
        .wrData(s_reg.cfg),
        .rdIdx(cmdArg[SLOT_W-1:0]),
        .rdData(slotData)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Event sets are merged last so a set in the clearing cycle survives.
    always_comb begin
        s_next = s_reg;
        s_next.rValid = 1'b0;
        s_next.rLast = 1'b0;
        s_next.trig = 1'b0;
        s_next.ownTrig = 1'b0;
        s_next.abort = 1'b0;
        s_next.clr = 1'b0;
        s_next.nvWr = 1'b0;
        s_next.pValid = 1'b0;
        s_next.sumPrev = sum;
        if (calOn) begin
            s_next.cal = 1'b1;
        end
        if (cfgLoad) begin
            s_next.cfg = cfgIn;
        end
        // Overlapped subsystem work runs on; only the wait looks at it.
        if (s_reg.waitPend && !overlapBusy) begin
            s_next.waitPend = 1'b0;
        end
        // Option report streams one field per cycle.
        if (s_reg.optBusy) begin
            s_next.rValid = 1'b1;
            s_next.rData = optField(s_reg.optIdx);
            s_next.rLast = s_reg.optIdx == OPT_LAST;
            s_next.optBusy = s_reg.optIdx != OPT_LAST;
            s_next.optIdx = s_reg.optIdx + 4'h1;
        end
        if (take) begin
            if (cmd != CMD_WAI) begin
                s_next.waitPend = 1'b0;
            end
            unique case (cmd)
                CMD_CLS: begin
                    s_next.evtReg = 8'h00;
                    s_next.clr = 1'b1;
                end
                CMD_ESE: begin
                    s_next.evtMask = cmdArg;
                    s_next.nvWr = 1'b1;
                end
                CMD_ESEQ: begin
                    s_next.rValid = 1'b1;
                    s_next.rData = s_reg.evtMask;
                    s_next.rLast = 1'b1;
                end
                CMD_ESRQ: begin
                    s_next.rValid = 1'b1;
                    s_next.rData = s_reg.evtReg;
                    s_next.rLast = 1'b1;
                    s_next.evtReg = 8'h00;
                end
                CMD_OPTQ: begin
                    // Query only: the installed set is a constant.
                    s_next.optBusy = 1'b1;
                    s_next.optIdx = 4'h0;
                end
                CMD_PSC: begin
                    s_next.clrFlag = cmdArg[0];
                    s_next.nvWr = 1'b1;
                end
                CMD_PSCQ: begin
                    s_next.rValid = 1'b1;
                    s_next.rData = {7'h00, s_reg.clrFlag};
                    s_next.rLast = 1'b1;
                end
                CMD_RCL: begin
                    s_next.cfg = slotData;
                    s_next.cal = 1'b0;
                    s_next.abort = 1'b1;
                end
                CMD_SRE: begin
                    s_next.reqMask = cmdArg;
                    s_next.nvWr = 1'b1;
                end
                CMD_SREQ: begin
                    s_next.rValid = 1'b1;
                    s_next.rData = s_reg.reqMask;
                    s_next.rLast = 1'b1;
                end
                CMD_STBQ: begin
                    // Plain read: no bit of the status byte is touched.
                    s_next.rValid = 1'b1;
                    s_next.rData = stb;
                    s_next.rLast = 1'b1;
                end
                CMD_WAI: begin
                    s_next.waitPend = overlapBusy;
                end
                CMD_RST, CMD_TRG, CMD_SAV, CMD_OTHER: begin
                end
            endcase
        end
        // Reset and device clear share one path; enable masks are kept.
        if (doReset) begin
            s_next.cfg = CFG_DEFAULT;
            s_next.evtReg = 8'h00;
            s_next.rfs = 1'b0;
            s_next.clr = 1'b1;
        end
        if (doTrig) begin
            s_next.trig = 1'b1;
            s_next.ownTrig = s_next.cfg[F_TSRC +: 2] == TSRC_BUS;
        end
        // Power-up either clears the masks or reloads them.
        if (powerUp) begin
            s_next.clrFlag = nvClearFlag;
            s_next.cfg = CFG_DEFAULT;
            s_next.reqMask = nvClearFlag ? MASK_RESET : nvRequestMask;
            s_next.evtMask = nvClearFlag ? MASK_RESET : nvEventMask;
            s_next.evtReg = 8'h00;
            s_next.evtReg[ESR_PWR] = 1'b1;
            // A fresh start drops any old request.
            s_next.rfs = 1'b0;
            s_next.sumPrev = 1'b0;
        end
        // Serial poll reports the request flag, then drops only it.
        if (pollReq) begin
            s_next.pValid = 1'b1;
            s_next.pData = stb;
            s_next.pData[STB_SUM] = s_reg.rfs;
            s_next.rfs = 1'b0;
        end
        s_next.evtReg = s_next.evtReg | eventSet;
        if (sum && !s_reg.sumPrev && !powerUp) begin
            s_next.rfs = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_reg <= CORE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // The request line follows the flag with no extra stage.
    assign srq = s_reg.rfs;
    assign respValid = s_reg.rValid;
    assign respData = s_reg.rData;
    assign respLast = s_reg.rLast;
    assign pollValid = s_reg.pValid;
    assign pollData = s_reg.pData;
    assign statusClear = s_reg.clr;
    assign nvWrite = s_reg.nvWr;
    assign nvClearFlagOut = s_reg.clrFlag;
    assign nvRequestMaskOut = s_reg.reqMask;
    assign nvEventMaskOut = s_reg.evtMask;
    assign cfgOut = s_reg.cfg;
    assign calEnable = s_reg.cal;
    assign busTrigger = s_reg.trig;
    assign transientTrig = s_reg.ownTrig;
    assign trigAbort = s_reg.abort;
    assign waitHold = s_reg.waitPend;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_zero_mask;
        @(posedge clk_sys) disable iff (!resetn)
        (s_reg.reqMask == 8'h00) [*2] |-> !sum ##1 !(s_reg.rfs && !$past(s_reg.rfs));
    endproperty
    a_zero_mask: assert property (p_zero_mask) else $error("Request raised with zero mask.");

    property p_poll_clear;
        @(posedge clk_sys) disable iff (!resetn)
        pollReq && !(sum && !s_reg.sumPrev) |=> !srq && pollValid;
    endproperty
    a_poll_clear: assert property (p_poll_clear) else $error("Poll did not clear request.");

    property p_poll_bit;
        @(posedge clk_sys) disable iff (!resetn)
        pollReq |=> pollData[STB_SUM] == $past(s_reg.rfs);
    endproperty
    a_poll_bit: assert property (p_poll_bit) else $error("Poll bit six is wrong.");

    property p_stb_read;
        @(posedge clk_sys) disable iff (!resetn)
        take && cmd == CMD_STBQ && !pollReq && !doReset && eventSet == 8'h00 && !powerUp
        |=> respValid && respData == $past(stb) && s_reg.evtReg == $past(s_reg.evtReg);
    endproperty
    a_stb_read: assert property (p_stb_read) else $error("Status read changed state.");

    property p_esr_read;
        @(posedge clk_sys) disable iff (!resetn)
        take && cmd == CMD_ESRQ && !powerUp |=> respData == $past(s_reg.evtReg)
        && s_reg.evtReg == $past(eventSet);
    endproperty
    a_esr_read: assert property (p_esr_read) else $error("Event read did not clear.");

    property p_reset_masks;
        @(posedge clk_sys) disable iff (!resetn)
        devClear && !powerUp && !take |=> s_reg.reqMask == $past(s_reg.reqMask)
        && s_reg.evtMask == $past(s_reg.evtMask) && s_reg.cfg == CFG_DEFAULT && statusClear;
    endproperty
    a_reset_masks: assert property (p_reset_masks) else $error("Clear touched masks.");

    property p_recall;
        @(posedge clk_sys) disable iff (!resetn)
        take && cmd == CMD_RCL && !calOn |=> trigAbort && !calEnable;
    endproperty
    a_recall: assert property (p_recall) else $error("Recall did not abort.");

    property p_bus_trig;
        @(posedge clk_sys) disable iff (!resetn)
        take && cmd == CMD_TRG |=> busTrigger;
    endproperty
    a_bus_trig: assert property (p_bus_trig) else $error("Bus trigger missing.");

    property p_wait_drop;
        @(posedge clk_sys) disable iff (!resetn)
        waitHold && take && cmd != CMD_WAI |=> !waitHold;
    endproperty
    a_wait_drop: assert property (p_wait_drop) else $error("Wait not abandoned.");

    property p_pon_clear;
        @(posedge clk_sys) disable iff (!resetn)
        powerUp && nvClearFlag |=> s_reg.reqMask == 8'h00 && s_reg.evtMask == 8'h00 ##1 !srq;
    endproperty
    a_pon_clear: assert property (p_pon_clear) else $error("Masks kept at power-up.");

    property p_opt_len;
        @(posedge clk_sys) disable iff (!resetn)
        take && cmd == CMD_OPTQ |=> ##14 respValid && respLast;
    endproperty
    a_opt_len: assert property (p_opt_len) else $error("Option list length wrong.");

    c_srq: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(srq));
    c_poll: cover property (@(posedge clk_sys) disable iff (!resetn) pollReq && srq);
    c_wait: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(waitHold));
    c_recall: cover property (@(posedge clk_sys) disable iff (!resetn) trigAbort);
endmodule

// [tb/ccsu_host_model.sv]
// Purpose: Serial-poll side of the remote bus controller.
// Assumes: Polls only when the bench asks, after lag clock cycles.
// Notes: Keeps the last polled byte; slow answers come from a larger lag.
`timescale 1ns/10ps
module ccsu_host_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Bench control
    input wire logic pollGo,
    input wire logic [3:0] lag,
    // Device poll port
    output logic pollReq,
    input wire logic pollValid,
    input wire logic [7:0] pollData,
    output logic [7:0] lastPoll
);
    // One request pulse per poll; the byte is taken in the cycle where it stands.
    initial begin
        pollReq = 1'b0;
        lastPoll = 8'h00;
        forever begin
            @(posedge clk_sys);
            if (pollGo === 1'b1 && resetn === 1'b1) begin
                repeat (lag) @(posedge clk_sys);
                #2 pollReq = 1'b1;
                @(posedge clk_sys) #2 pollReq = 1'b0;
                if (pollValid === 1'b1) lastPoll = pollData;
            end
        end
    end
endmodule

// [tb/common_command_status_unit_tb_top.sv]
// Purpose: Self-checking bench for the common command and status unit.
// Assumes: Inputs change 2 ns after the rising edge of a 25 ns clock.
// Notes: Expected values come from a small model kept in the bench.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errorCnt++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module common_command_status_unit_tb_top
    import ccsu_pkg::*;
;
    logic clk_sys = '0, resetn = '0, cmdValid = '0, devClear = '0, groupTrig = '0;
    logic operSummary = '0, questSummary = '0, msgAvail = '0, powerUp = '0, pollGo = '0;
    logic nvClearFlag = '0, cfgLoad = '0, calOn = '0, overlapBusy = '0;
    logic [3:0] cmdCode = '0, lag = '0;
    logic [7:0] cmdArg = '0, eventSet = '0, nvRequestMask = '0, nvEventMask = '0;
    logic [CFG_W-1:0] cfgIn = '0, cfgOut;
    logic cmdReady, respValid, respLast, pollReq, pollValid, srq, statusClear, nvWrite;
    logic nvClearFlagOut, calEnable, busTrigger, transientTrig, trigAbort, waitHold;
    logic [7:0] respData, pollData, nvRequestMaskOut, nvEventMaskOut, lastPoll;
    logic [7:0] sre = '0, ese = '0, evt = '0, stb;
    logic [CFG_W-1:0] slot [SLOTS];
    logic prevSum = '0, srqF = '0;
    int errorCnt = 0, checked = 0, seed = 50479, i, k, s;

    ccsu_core u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdArg(cmdArg), .cmdReady(cmdReady), .respValid(respValid), .respData(respData),
        .respLast(respLast), .devClear(devClear), .groupTrig(groupTrig), .pollReq(pollReq),
        .pollValid(pollValid), .pollData(pollData), .srq(srq), .operSummary(operSummary),
        .questSummary(questSummary), .msgAvail(msgAvail), .eventSet(eventSet),
        .statusClear(statusClear), .powerUp(powerUp), .nvClearFlag(nvClearFlag),
        .nvRequestMask(nvRequestMask), .nvEventMask(nvEventMask), .nvWrite(nvWrite),
        .nvClearFlagOut(nvClearFlagOut), .nvRequestMaskOut(nvRequestMaskOut),
        .nvEventMaskOut(nvEventMaskOut), .cfgLoad(cfgLoad), .cfgIn(cfgIn), .cfgOut(cfgOut),
        .calEnable(calEnable), .calOn(calOn), .busTrigger(busTrigger),
        .transientTrig(transientTrig), .trigAbort(trigAbort), .overlapBusy(overlapBusy),
        .waitHold(waitHold));
    ccsu_host_model u_host (.clk_sys(clk_sys), .resetn(resetn), .pollGo(pollGo), .lag(lag),
        .pollReq(pollReq), .pollValid(pollValid), .pollData(pollData), .lastPoll(lastPoll));

    // Free-running system clock.
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Expected status byte from the model's masks and event register.
    function automatic logic [7:0] stbExp();
        logic [7:0] b;
        b = {operSummary, 1'b0, |(evt & ese), msgAvail, questSummary, 3'h0};
        return b | {1'b0, |(b & sre), 6'h00};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys) #2;
    endtask
    task automatic pulse(ref logic x);
        x = 1'b1;
        tick(1);
        x = 1'b0;
    endtask
    // The idle cycle first keeps cmdValid from being written twice in one step.
    task automatic cmd(input logic [3:0] c, input logic [7:0] a);
        int n;
        n = 0;
        tick(1);
        cmdValid = 1'b1;
        cmdCode = c;
        cmdArg = a;
        while (cmdReady !== 1'b1 && n < 40) begin
            n++;
            tick(1);
        end
        tick(1);
        cmdValid = 1'b0;
    endtask
    task automatic q(input logic [3:0] c, input logic [7:0] e);
        cmd(c, 8'h00);
        `CHK({respValid, respLast, respData}, {2'b11, e})
    endtask
    // The request flag follows every rise of the summary, so track it at each step.
    task automatic settle();
        tick(3);
        stb = stbExp();
        if (stb[6] && !prevSum) srqF = 1'b1;
        prevSum = stb[6];
        `CHK(srq, srqF)
    endtask
    task automatic complete_run();
        $display("checked=%0d errors=%0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog: the sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk_sys);
        errorCnt++;
        complete_run();
    end

    // Main sequence.
    initial begin
        for (i = 0; i < SLOTS; i++) slot[i] = CFG_DEFAULT;
        repeat (4) @(posedge clk_sys);
        #2 resetn = 1'b1;
        q(CMD_SREQ, 8'h00);
        for (k = 1; k >= 0; k--) begin
            nvClearFlag = k[0];
            nvRequestMask = 8'($random(seed)) | 8'h20;
            nvEventMask = 8'($random(seed)) | 8'h80;
            pulse(powerUp);
            evt = 8'h80;
            sre = k ? 8'h00 : nvRequestMask;
            ese = k ? 8'h00 : nvEventMask;
            settle();
            q(CMD_SREQ, sre);
            q(CMD_ESEQ, ese);
        end
        for (k = 0; k < 4; k++) begin
            sre = k ? 8'($random(seed)) : 8'h00;
            ese = 8'($random(seed));
            operSummary = 1'($random(seed));
            settle();
            cmd(CMD_SRE, sre);
            settle();
            cmd(CMD_ESE, ese);
            settle();
            eventSet = 8'($random(seed)) & 8'hbd;
            tick(1);
            evt = evt | eventSet;
            eventSet = 8'h00;
            settle();
            q(CMD_STBQ, stb);
            lag = 4'($random(seed)) & 4'h3;
            pulse(pollGo);
            tick(8);
            `CHK(lastPoll, {stb[7], srqF, stb[5:0]})
            srqF = 1'b0;
            settle();
            q(CMD_STBQ, stb);
            q(CMD_ESRQ, evt);
            evt = 8'h00;
            settle();
            q(CMD_STBQ, stb);
        end
        cfgIn = CFG_W'({$random(seed), $random(seed)});
        cfgIn[3:2] = TSRC_BUS;
        pulse(cfgLoad);
        s = {$random(seed)} % SLOTS;
        cmd(CMD_SAV, 8'(s));
        slot[s] = cfgIn;
        cfgIn = ~cfgIn;
        cfgIn[3:2] = TSRC_IMM;
        pulse(cfgLoad);
        pulse(calOn);
        cmd(CMD_RCL, 8'(s));
        `CHK({trigAbort, calEnable, cfgOut}, {2'b10, slot[s]})
        cmd(CMD_TRG, 8'h00);
        `CHK({busTrigger, transientTrig}, 2'b11)
        pulse(groupTrig);
        `CHK({busTrigger, transientTrig}, 2'b11)
        cmd(CMD_RCL, 8'((s + 1) % SLOTS));
        `CHK(cfgOut, slot[(s + 1) % SLOTS])
        operSummary = 1'b0;
        for (k = 0; k < 2; k++) begin
            eventSet = 8'h10;
            tick(1);
            eventSet = 8'h00;
            tick(2);
            if (k) cmd(CMD_RST, 8'h00);
            else pulse(devClear);
            `CHK({statusClear, cfgOut}, {1'b1, CFG_DEFAULT})
            evt = 8'h00;
            srqF = 1'b0;
            settle();
            q(CMD_SREQ, sre);
            q(CMD_ESRQ, 8'h00);
        end
        for (k = 0; k < 2; k++) begin
            overlapBusy = 1'b1;
            cmd(CMD_WAI, 8'h00);
            tick(3);
            `CHK(waitHold, 1'b1)
            if (k) cmd(CMD_OTHER, 8'h00);
            else overlapBusy = 1'b0;
            tick(2);
            `CHK(waitHold, 1'b0)
        end
        overlapBusy = 1'b0;
        cmd(CMD_PSC, 8'h01);
        `CHK({nvWrite, nvClearFlagOut}, 2'b11)
        `CHK({nvRequestMaskOut, nvEventMaskOut}, {sre, ese})
        q(CMD_PSCQ, 8'h01);
        eventSet = 8'h04;
        tick(1);
        eventSet = 8'h00;
        cmd(CMD_CLS, 8'h00);
        `CHK(statusClear, 1'b1)
        q(CMD_ESRQ, 8'h00);
        cmd(CMD_OPTQ, 8'h00);
        tick(1);
        for (i = 0; i < OPT_N; i++) begin
            `CHK(respData, OPT_INSTALLED[i] ? 8'(i + 1) : 8'h00)
            `CHK({respValid, respLast}, {1'b1, 1'(i == OPT_N - 1)})
            tick(1);
        end
        complete_run();
    end
endmodule
